// ===== inc/uar_pkg.sv
// uar_pkg: constants for the serial address recognition block
// assumes an 8-bit special-function register port, byte wide only
package uar_pkg;
  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 8;
  localparam logic [7:0]  OFF_ADDR_VALUE  = 8'ha9;
  localparam logic [7:0]  OFF_ADDR_MASK   = 8'hb9;
  localparam logic [7:0]  OFF_MATCH_STAT  = 8'hc9;
  localparam logic [7:0]  RST_ADDR_VALUE  = 8'h00;
  localparam logic [7:0]  RST_ADDR_MASK   = 8'h00;
  localparam logic [7:0]  RD_UNMAPPED     = 8'h00;
  localparam int          STAT_GIVEN_BIT  = 0;
  localparam int          STAT_BCAST_BIT  = 1;
  localparam int          STAT_ACCEPT_BIT = 2;
endpackage

// ===== hw/uar_match_bit.sv
// uar_match_bit: per-bit compare of a received byte against given and broadcast forms
// assumes inputs are registered values from the same clock
`timescale 1ns/10ps
module uar_match_bit
  import uar_pkg::*;
(
  input  wire logic [DATA_W-1:0] rxByte,
  input  wire logic [DATA_W-1:0] addrValue,
  input  wire logic [DATA_W-1:0] addrMask,
  output logic                   givenHit,
  output logic                   bcastHit
);
  logic [DATA_W-1:0] bcastForm;
  logic [DATA_W-1:0] givenOk;
  logic [DATA_W-1:0] bcastOk;

  assign bcastForm = addrValue | addrMask; // [RULE_01]

  genvar i;
  generate
    for (i = 0; i < DATA_W; i++) begin : gBit
      // mask zero means the position is ignored
      assign givenOk[i] = ~addrMask[i] | (rxByte[i] == addrValue[i]); // [RULE_06]
      // zero in the or result is a don't-care
      assign bcastOk[i] = ~bcastForm[i] | rxByte[i]; // [RULE_01]
    end
  endgenerate

  assign givenHit = &givenOk; // [RULE_03]
  assign bcastHit = &bcastOk; // [RULE_03]
endmodule

// ===== hw/uar_addr_recog.sv
// uar_addr_recog: slave address recognition for a multiprocessor serial port
// assumes the receiver presents a complete address byte with a one-cycle strobe
//
// Overview of operation
// RULE_01: broadcast address is value OR mask; zero bits there are don't-care.
// RULE_02: reset loads both value and mask registers with zero.
// RULE_03: with both registers zero, any received address byte is accepted.
// RULE_04: mask register at B9h, eight bits, zero at reset, whole byte only.
// RULE_05: value register at A9h, eight bits, zero at reset, whole byte only.
// RULE_06: given address matches where mask bits are one; mask zero bits ignored.
`timescale 1ns/10ps
module uar_addr_recog
  import uar_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [DATA_W-1:0] regWdata,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic      [DATA_W-1:0] regRdata,
  input  wire logic [DATA_W-1:0] rxByte,
  input  wire logic              rxAddrValid,
  output logic                   addrAccept,
  output logic                   addrGiven,
  output logic                   addrBcast,
  output logic                   matchValid
);
  logic [DATA_W-1:0] slaveAddrValue_r;
  logic [DATA_W-1:0] slaveAddrValue_nxt;
  logic [DATA_W-1:0] slaveAddrMask_r;
  logic [DATA_W-1:0] slaveAddrMask_nxt;
  logic [DATA_W-1:0] regRdata_r;
  logic [DATA_W-1:0] regRdata_nxt;
  logic              addrAccept_r;
  logic              addrAccept_nxt;
  logic              addrGiven_r;
  logic              addrGiven_nxt;
  logic              addrBcast_r;
  logic              addrBcast_nxt;
  logic              matchValid_r;
  logic              matchValid_nxt;
  logic              givenHit;
  logic              bcastHit;

  uar_match_bit uMatch (
    .rxByte    (rxByte),
    .addrValue (slaveAddrValue_r),
    .addrMask  (slaveAddrMask_r),
    .givenHit  (givenHit),
    .bcastHit  (bcastHit)
  );

  // register writes, whole byte only
  always_comb begin
    slaveAddrValue_nxt = slaveAddrValue_r;
    slaveAddrMask_nxt  = slaveAddrMask_r;
    if (regWr) begin
      case (regAddr)
        OFF_ADDR_VALUE: slaveAddrValue_nxt = regWdata; // [RULE_05]
        OFF_ADDR_MASK:  slaveAddrMask_nxt  = regWdata; // [RULE_04]
        default: begin
        end
      endcase
    end
  end

  // read data valid in the cycle after the strobe only
  always_comb begin
    regRdata_nxt = RD_UNMAPPED;
    if (regRd) begin
      case (regAddr)
        OFF_ADDR_VALUE: regRdata_nxt = slaveAddrValue_r; // [RULE_05]
        OFF_ADDR_MASK:  regRdata_nxt = slaveAddrMask_r;  // [RULE_04]
        OFF_MATCH_STAT: begin
          regRdata_nxt                  = RD_UNMAPPED;
          regRdata_nxt[STAT_GIVEN_BIT]  = addrGiven_r;
          regRdata_nxt[STAT_BCAST_BIT]  = addrBcast_r;
          regRdata_nxt[STAT_ACCEPT_BIT] = addrAccept_r;
        end
        default: regRdata_nxt = RD_UNMAPPED;
      endcase
    end
  end

  // result held until next address byte; pulse marks a fresh decision
  always_comb begin
    addrGiven_nxt  = addrGiven_r;
    addrBcast_nxt  = addrBcast_r;
    addrAccept_nxt = addrAccept_r;
    matchValid_nxt = 1'b0;
    if (rxAddrValid) begin
      addrGiven_nxt  = givenHit;
      addrBcast_nxt  = bcastHit;
      addrAccept_nxt = givenHit | bcastHit; // [RULE_03]
      matchValid_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      slaveAddrValue_r <= RST_ADDR_VALUE; // [RULE_02]
      slaveAddrMask_r  <= RST_ADDR_MASK;  // [RULE_02]
      regRdata_r       <= RD_UNMAPPED;
      addrGiven_r      <= 1'b0;
      addrBcast_r      <= 1'b0;
      addrAccept_r     <= 1'b0;
      matchValid_r     <= 1'b0;
    end else begin
      slaveAddrValue_r <= slaveAddrValue_nxt;
      slaveAddrMask_r  <= slaveAddrMask_nxt;
      regRdata_r       <= regRdata_nxt;
      addrGiven_r      <= addrGiven_nxt;
      addrBcast_r      <= addrBcast_nxt;
      addrAccept_r     <= addrAccept_nxt;
      matchValid_r     <= matchValid_nxt;
    end
  end

  assign regRdata   = regRdata_r;
  assign addrGiven  = addrGiven_r;
  assign addrBcast  = addrBcast_r;
  assign addrAccept = addrAccept_r;
  assign matchValid = matchValid_r;
endmodule

// ===== testbench/uar_rx_master.sv
// remote serial master model: presents address bytes
// assumes calls right after a rising clk edge
`timescale 1ns/10ps
module uar_rx_master (
  input  wire logic       clk,
  output logic [7:0]      rxByte,
  output logic            rxAddrValid
);
  initial {rxByte, rxAddrValid} = 9'h000;
  task automatic sendAddr(input logic [7:0] b);
    {rxByte, rxAddrValid} <= {b, 1'b1};
    @(posedge clk);
    // inverted byte when idle, so a stale value never looks valid
    {rxByte, rxAddrValid} <= {~b, 1'b0};
  endtask
endmodule

// ===== testbench/uar_addr_recog_properties.sv
// checker: match flags and register reads of uar_addr_recog
// assumes bound to the top module, one clock domain
`timescale 1ns/10ps
module uar_addr_recog_chk
  import uar_pkg::*;
(
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic       regWr,
  input wire logic       regRd,
  input wire logic       rxAddrValid,
  input wire logic       addrAccept,
  input wire logic       addrGiven,
  input wire logic       addrBcast,
  input wire logic       matchValid,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  input wire logic [7:0] rxByte
);
  logic [7:0] val_r, msk_r;
  always_ff @(posedge clk or negedge resetn)
    if (!resetn) {val_r, msk_r} <= 16'h0000;
    else if (regWr && regAddr == OFF_ADDR_VALUE) val_r <= regWdata;
    else if (regWr && regAddr == OFF_ADDR_MASK) msk_r <= regWdata;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence sJudged; rxAddrValid ##1 matchValid; endsequence
  a_match_pulse: assert property (rxAddrValid |=> matchValid) else $error("no match pulse");
  a_given_hit: assert property (
    sJudged |-> addrGiven == ((($past(rxByte) ^ $past(val_r)) & $past(msk_r)) == 8'h00))
    else $error("given flag wrong");
  a_bcast_hit: assert property (
    sJudged |-> addrBcast == &($past(rxByte) | ~($past(val_r) | $past(msk_r))))
    else $error("broadcast flag wrong");
  a_open_accept: assert property (
    rxAddrValid && val_r == 8'h00 && msk_r == 8'h00 |=> addrAccept)
    else $error("open address refused");
  a_value_read: assert property (
    regRd && regAddr == OFF_ADDR_VALUE |=> regRdata == $past(val_r))
    else $error("value read wrong");
  a_mask_read: assert property (
    regRd && regAddr == OFF_ADDR_MASK |=> regRdata == $past(msk_r))
    else $error("mask read wrong");
  // read data stand one cycle only, then fall back to the idle value
  a_rdata_idle: assert property (!regRd |=> regRdata == RD_UNMAPPED) else $error("read data not idle");
  a_status_read: assert property (
    regRd && regAddr == OFF_MATCH_STAT |=> regRdata == {5'h00, $past(addrAccept), $past(addrBcast), $past(addrGiven)})
    else $error("status read wrong");
  a_pulse_only: assert property (!rxAddrValid |=> !matchValid) else $error("stray match pulse");
  a_flags_hold: assert property (
    !rxAddrValid |=> $stable({addrGiven, addrBcast, addrAccept}))
    else $error("flags moved without byte");
endmodule
bind uar_addr_recog uar_addr_recog_chk chk (.*);

// ===== testbench/uar_addr_recog_tb.sv
// bench: register and address match scenarios
// assumes dut and master model share clk
`timescale 1ns/10ps
module uar_addr_recog_tb;
  import uar_pkg::*;
  logic       clk = 0, resetn = 0, regWr = 0, regRd = 0, rxAddrValid, addrAccept, addrGiven, addrBcast, matchValid;
  logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata, rxByte;
  int         mismatches = 0, testsRun = 0;
  always #10 clk = ~clk;
  uar_rx_master rm (.clk(clk), .rxByte(rxByte), .rxAddrValid(rxAddrValid));
  uar_addr_recog dut (
    .clk         (clk),
    .resetn      (resetn),
    .regAddr     (regAddr),
    .regWdata    (regWdata),
    .regWr       (regWr),
    .regRd       (regRd),
    .regRdata    (regRdata),
    .rxByte      (rxByte),
    .rxAddrValid (rxAddrValid),
    .addrAccept  (addrAccept),
    .addrGiven   (addrGiven),
    .addrBcast   (addrBcast),
    .matchValid  (matchValid)
  );
  task automatic chk(input logic [7:0] seen, exp);
    testsRun++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic acc(input logic wr, input logic [7:0] a, d);
    @(posedge clk);
    {regWr, regRd, regAddr, regWdata} <= {wr, !wr, a, d};
    @(posedge clk);
    {regWr, regRd} <= 2'b00;
    #1 if (!wr) chk(regRdata, d);
  endtask
  task automatic hit(input logic [7:0] b, input logic [3:0] exp);
    @(posedge clk);
    rm.sendAddr(b);
    #1 chk({4'h0, matchValid, addrAccept, addrBcast, addrGiven}, {4'h0, exp});
  endtask
  task automatic resetScn();
    acc(0, OFF_ADDR_VALUE, 8'h00);
    acc(0, OFF_ADDR_MASK, 8'h00);
    hit(8'h5a, 4'hf);
  endtask
  task automatic regScn();
    acc(1, OFF_ADDR_VALUE, 8'h56);
    acc(1, OFF_ADDR_MASK, 8'hfc);
    acc(1, 8'h00, 8'h33);
    acc(0, 8'h00, 8'h00);
    acc(0, OFF_ADDR_VALUE, 8'h56);
    acc(0, OFF_ADDR_MASK, 8'hfc);
  endtask
  task automatic matchScn();
    hit(8'h57, 4'hd);
    acc(0, OFF_MATCH_STAT, 8'h05);
    hit(8'hfe, 4'he);
    acc(0, OFF_MATCH_STAT, 8'h06);
    hit(8'h12, 4'h8);
  endtask
  // mid-run reset must drop programmed values, so a refused byte is accepted again
  task automatic resetAgainScn();
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    acc(0, OFF_ADDR_VALUE, 8'h00);
    acc(0, OFF_ADDR_MASK, 8'h00);
    hit(8'h12, 4'hf);
    acc(0, OFF_MATCH_STAT, 8'h07);
  endtask
  task automatic reportAndStop();
    $display("checks %0d mismatches %0d", testsRun, mismatches);
    if (mismatches == 0 && testsRun > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    resetScn();
    regScn();
    matchScn();
    resetAgainScn();
    reportAndStop();
  end
endmodule
